// file: design/usm_top.v
// Synchronous master transmitter with baud generator and AHB-Lite registers.
// Assumes a single AHB-Lite master; hready is this slave's hreadyout.
// Operation
// (RULE1) Async low speed: osc over 64(X+1)
// (RULE2) Async high speed: osc over 16(X+1)
// (RULE3) Sync: osc over 4(X+1), speed ignored
// (RULE4) Divisor is unsigned 8-bit register value
// (RULE5) Half duplex: transmit and receive exclude
// (RULE6) Sync select plus port enable claim pins
// (RULE7) Clock source select makes us master
// (RULE8) Load shifter only after last bit
// (RULE9) Transfer takes one instruction cycle, flag sets
// (RULE10) Flag set always, cleared only by load
// (RULE11) Interrupt request only with enable set
// (RULE12) Shifter-empty bit read-only, no interrupt
// (RULE13) Software sets up divisor, modes, enable
// (RULE14) Ninth bit sent when nine-bit enabled
// (RULE15) Software starts by writing buffer
// (RULE16) Flag drop valid second instruction cycle
// (RULE17) Reset: status 0x02, divisor zero
// (RULE18) Baud timer free-running, divisor sets period
// (RULE19) Divisor write restarts baud timer
// (RULE20) Shift out LSB first, one per clock
`timescale 1ns/1ps
`include "usm_defs.vh"

module usm_top (
	input  wire        clk,
	input  wire        nrst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	output wire        ckOut,
	output wire        ckOe,
	output wire        dtOut,
	output wire        dtOe,
	output wire        baudTick,
	output wire        rxInhibit,
	output wire        txIrq
);

	// ==========================================
	// Register state
	reg  [7:0] txCtl_q;
	reg  [7:0] rxCtl_q;
	reg  [7:0] divisor_q;
	reg  [7:0] txBuf_q;
	reg        bufD9_q;
	reg        bufFull_q;
	reg        flag_q;
	reg        irqEna_q;

	// ==========================================
	// Bus phase state
	reg        wrPend_q;
	reg  [7:0] wrAddr_q;

	// ==========================================
	// Transfer and flag timing
	reg  [2:0] loadCnt_q;
	reg        loading_q;
	reg  [3:0] clrCnt_q;
	reg        clrPend_q;

	// ==========================================
	// Internal nets
	wire       addrPhase;
	wire       wrDivisor;
	wire       wrTxBuf;
	wire       wrTxCtl;
	wire       wrRxCtl;
	wire       wrIrqCtl;
	wire [7:0] wrByte;
	wire       modeSync;
	wire       portOn;
	wire       master;
	wire       txEnable;
	wire       rxWanted;
	wire       txActive;
	wire       shBusy;
	wire       shLoad;
	wire       brgTick;
	wire [1:0] preSel;
	wire       shift_register_empty;
	wire       shAbort;
	wire       loadDone;
	wire       clrDone;
	wire       linkOn;
	wire       txPath;
	wire       wrPhase;
	wire       rdPhase;
	wire [7:0] divLoad;

	localparam [31:0] LOAD_LAST_W = `USM_TCY_CLKS - 1;
	localparam [31:0] CLR_LAST_W  = `USM_TCY_CLKS * `USM_FLAG_TCY - 1;
	localparam [2:0]  LOAD_LAST   = LOAD_LAST_W[2:0];
	localparam [3:0]  CLR_LAST    = CLR_LAST_W[3:0];

	// ==========================================
	// Read decode
	function [7:0] readReg;
		input [7:0] addr;
		input [7:0] txCtl;
		input [7:0] rxCtl;
		input [7:0] divisor;
		input [7:0] txBuf;
		input       trmtBit;
		input       flagBit;
		input       enaBit;
		begin
			case (addr)
				`USM_OFS_TXCTL: begin
					readReg = {txCtl[7:4], 1'b0, txCtl[2], trmtBit, txCtl[0]}; // [RULE12] [RULE17]
				end
				`USM_OFS_RXCTL: begin
					readReg = {rxCtl[7:3], 3'b000};
				end
				`USM_OFS_DIVISOR: begin
					readReg = divisor;
				end
				`USM_OFS_TXBUF: begin
					readReg = txBuf;
				end
				`USM_OFS_IRQCTL: begin
					readReg = {6'b000000, enaBit, flagBit};
				end
				default: begin
					readReg = 8'h00;
				end
			endcase
		end
	endfunction

	// ==========================================
	// Map decode
	function inMap;
		input [31:0] addr;
		begin
			inMap = (addr[31:8] == 24'h00_0000);
		end
	endfunction

	// ==========================================
	// AHB-Lite slave
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addrPhase = hsel && hready && htrans[1];
	assign wrPhase   = addrPhase && hwrite && inMap(haddr);
	assign rdPhase   = addrPhase && !hwrite;
	assign wrByte    = hwdata[7:0];

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata   <= 32'h0000_0000;
		end else begin
			wrPend_q <= wrPhase;
			if (addrPhase) begin
				wrAddr_q <= haddr[7:0];
			end
			if (rdPhase) begin
				hrdata <= inMap(haddr) ?
				          {24'h00_0000, readReg(haddr[7:0], txCtl_q, rxCtl_q, divisor_q, txBuf_q,
				                                shift_register_empty, flag_q, irqEna_q)} : 32'h0000_0000;
			end
		end
	end

	// ==========================================
	// Write strobes
	assign wrTxCtl   = wrPend_q && (wrAddr_q == `USM_OFS_TXCTL);
	assign wrRxCtl   = wrPend_q && (wrAddr_q == `USM_OFS_RXCTL);
	assign wrDivisor = wrPend_q && (wrAddr_q == `USM_OFS_DIVISOR);
	assign wrTxBuf   = wrPend_q && (wrAddr_q == `USM_OFS_TXBUF);
	assign wrIrqCtl  = wrPend_q && (wrAddr_q == `USM_OFS_IRQCTL);

	// ==========================================
	// Control registers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txCtl_q   <= `USM_TXCTL_RST; // [RULE17]
			rxCtl_q   <= `USM_RXCTL_RST;
			divisor_q <= `USM_DIVISOR_RST; // [RULE17]
			irqEna_q  <= 1'b0;
		end else begin
			if (wrTxCtl) begin
				txCtl_q <= wrByte & `USM_TXCTL_WMASK; // [RULE12]
			end
			if (wrRxCtl) begin
				rxCtl_q <= wrByte & `USM_RXCTL_WMASK;
			end
			if (wrDivisor) begin
				divisor_q <= wrByte; // [RULE4]
			end
			if (wrIrqCtl) begin
				irqEna_q <= wrByte[`USM_IRQ_ENA];
			end
		end
	end

	// ==========================================
	// Mode decode
	assign modeSync = txCtl_q[`USM_TX_SYNC]; // [RULE6]
	assign portOn   = rxCtl_q[`USM_RX_SERIAL_PORT_ENABLE]; // [RULE6]
	assign master   = txCtl_q[`USM_TX_CLOCK_SOURCE_SELECT]; // [RULE7]
	assign txEnable = txCtl_q[`USM_TX_TRANSMIT_ENABLE];
	assign rxWanted = rxCtl_q[`USM_RX_SREN] || rxCtl_q[`USM_RX_CREN];
	assign linkOn   = modeSync && portOn && master; // [RULE6] [RULE7]
	assign txPath   = linkOn && txEnable;
	assign txActive = txPath && !rxWanted; // [RULE5]
	assign shAbort  = !txPath;
	assign preSel   = modeSync ? `USM_PRE_SYNC :
	                  (txCtl_q[`USM_TX_HIGH_SPEED_SELECT] ? `USM_PRE_ASYNC_HI : `USM_PRE_ASYNC_LO); // [RULE3]

	// ==========================================
	// Baud generator
	// New divisor reaches the timer in its write cycle
	assign divLoad = wrDivisor ? wrByte : divisor_q; // [RULE19]

	usm_brg u_brg (
		.clk     (clk),
		.nrst    (nrst),
		.divisor (divLoad),
		.restart (wrDivisor), // [RULE19]
		.preSel  (preSel),
		.tick    (brgTick)
	);

	// ==========================================
	// Tick output
	assign baudTick = brgTick;

	// ==========================================
	// Buffer to shifter transfer
	assign loadDone = loading_q && txActive && (loadCnt_q == LOAD_LAST);
	assign shLoad   = loadDone;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loadCnt_q <= 3'd0;
			loading_q <= 1'b0;
		end else if (!txActive) begin
			loadCnt_q <= 3'd0;
			loading_q <= 1'b0;
		end else if (loading_q) begin
			if (loadDone) begin
				loading_q <= 1'b0; // [RULE9]
				loadCnt_q <= 3'd0;
			end else begin
				loadCnt_q <= loadCnt_q + 3'd1;
			end
		end else if (bufFull_q && !shBusy) begin
			loading_q <= 1'b1; // [RULE8]
			loadCnt_q <= 3'd0;
		end
	end

	// ==========================================
	// Transmit buffer
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txBuf_q   <= `USM_TXBUF_RST;
			bufD9_q   <= 1'b0;
			bufFull_q <= 1'b0;
		end else begin
			if (wrTxBuf) begin
				txBuf_q   <= wrByte; // [RULE15]
				bufD9_q   <= txCtl_q[`USM_TX_D9]; // [RULE14]
				bufFull_q <= 1'b1;
			end else if (loadDone) begin
				bufFull_q <= 1'b0; // [RULE9]
			end
		end
	end

	// ==========================================
	// Buffer-empty flag with delayed clear
	assign clrDone = clrPend_q && (clrCnt_q == CLR_LAST);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clrCnt_q  <= 4'd0;
			clrPend_q <= 1'b0;
			flag_q    <= 1'b0;
		end else begin
			if (wrTxBuf) begin
				clrPend_q <= 1'b1; // [RULE16]
				clrCnt_q  <= 4'd0;
			end else if (clrDone) begin
				clrPend_q <= 1'b0;
			end else if (clrPend_q) begin
				clrCnt_q <= clrCnt_q + 4'd1;
			end
			if (loadDone || (txEnable && !bufFull_q && !clrPend_q)) begin
				flag_q <= 1'b1; // [RULE9] [RULE10]
			end else if (clrDone && bufFull_q) begin
				flag_q <= 1'b0; // [RULE10] [RULE16]
			end
		end
	end

	// ==========================================
	// Interrupt request
	assign txIrq = flag_q && irqEna_q; // [RULE11]

	// ==========================================
	// Shift register and pins
	wire shCk;
	wire shDt;

	usm_shift u_shift (
		.clk      (clk),
		.nrst     (nrst),
		.halfTick (brgTick),
		.load     (shLoad), // [RULE8]
		.loadData ({bufD9_q, txBuf_q}),
		.nineBit  (txCtl_q[`USM_TX_NINE]), // [RULE14]
		.abort    (shAbort),
		.ckOut    (shCk),
		.dtOut    (shDt),
		.busy     (shBusy)
	);

	// ==========================================
	// Pin drive
	assign shift_register_empty      = !shBusy; // [RULE12]
	assign ckOut     = shCk;
	assign ckOe      = linkOn; // [RULE7]
	assign dtOut     = shDt;
	assign dtOe      = modeSync && portOn && txEnable && !rxWanted; // [RULE5] [RULE6]
	assign rxInhibit = shBusy || loading_q || bufFull_q; // [RULE5]

	// ==========================================
	// Unused bus fields
	wire unusedBits;
	assign unusedBits = ^{hsize, htrans[0], hwdata[31:8]};

endmodule // usm_top

// file: design/usm_defs.vh
// Constants for the synchronous master transmitter and its baud generator.
// Assumes one system clock, four clock periods to an instruction cycle.
`ifndef USM_DEFS_VH
`define USM_DEFS_VH

// ==========================================
// Register byte offsets
`define USM_OFS_TXCTL      8'h00
`define USM_OFS_RXCTL      8'h04
`define USM_OFS_DIVISOR    8'h08
`define USM_OFS_TXBUF      8'h0C
`define USM_OFS_IRQCTL     8'h10

// ==========================================
// Transmit status/control fields
`define USM_TX_CLOCK_SOURCE_SELECT        7
`define USM_TX_NINE        6
`define USM_TX_TRANSMIT_ENABLE        5
`define USM_TX_SYNC        4
`define USM_TX_HIGH_SPEED_SELECT        2
`define USM_TX_SHIFT_REGISTER_EMPTY        1
`define USM_TX_D9          0
`define USM_TXCTL_WMASK    8'hF5
`define USM_TXCTL_RST      8'h02

// ==========================================
// Receive status/control fields
`define USM_RX_SERIAL_PORT_ENABLE        7
`define USM_RX_SREN        5
`define USM_RX_CREN        4
`define USM_RXCTL_WMASK    8'hF8
`define USM_RXCTL_RST      8'h00

// ==========================================
// Interrupt control fields
`define USM_IRQ_FLAG       0
`define USM_IRQ_ENA        1

// ==========================================
// Reset values
`define USM_DIVISOR_RST    8'h00
`define USM_TXBUF_RST      8'h00

// ==========================================
// Timing
`define USM_TCY_CLKS       4
`define USM_FLAG_TCY       2
`define USM_PRE_ASYNC_LO   2'd0
`define USM_PRE_ASYNC_HI   2'd1
`define USM_PRE_SYNC       2'd2
`define USM_DIV_ASYNC_LO   64
`define USM_DIV_ASYNC_HI   16
`define USM_DIV_SYNC_HALF  2
`define USM_PRE_LAST_LO    6'h3F
`define USM_PRE_LAST_HI    6'h0F
`define USM_PRE_LAST_SYNC  6'h01

`endif

// file: design/usm_brg.v
// Free-running baud timer: prescaler followed by an 8-bit period counter.
// Assumes restart is a one-cycle pulse from the divisor register write.
`timescale 1ns/1ps
`include "usm_defs.vh"

module usm_brg (
	input  wire       clk,
	input  wire       nrst,
	input  wire [7:0] divisor,
	input  wire       restart,
	input  wire [1:0] preSel,
	output reg        tick
);

	// ==========================================
	// Prescaler
	reg  [5:0] preCnt_q;
	reg  [7:0] divCnt_q;
	wire [5:0] preLast;
	wire       preTick;

	assign preLast = (preSel == `USM_PRE_ASYNC_LO) ? `USM_PRE_LAST_LO :
	                 (preSel == `USM_PRE_ASYNC_HI) ? `USM_PRE_LAST_HI : `USM_PRE_LAST_SYNC; // [RULE1] [RULE2] [RULE3]
	assign preTick = (preCnt_q >= preLast);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			preCnt_q <= 6'h00;
			divCnt_q <= 8'h00;
			tick     <= 1'b0;
		end else if (restart) begin
			preCnt_q <= 6'h00; // [RULE19]
			divCnt_q <= divisor; // [RULE19]
			tick     <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (preTick) begin
				preCnt_q <= 6'h00;
				if (divCnt_q == 8'h00) begin
					divCnt_q <= divisor; // [RULE4] [RULE18]
					tick     <= 1'b1;
				end else begin
					divCnt_q <= divCnt_q - 8'h01;
				end
			end else begin
				preCnt_q <= preCnt_q + 6'h01;
			end
		end
	end

endmodule // usm_brg

// file: design/usm_shift.v
// Transmit shift register driving clock and data lines, LSB first.
// Assumes halfTick pulses once per half bit period.
`timescale 1ns/1ps

module usm_shift (
	input  wire       clk,
	input  wire       nrst,
	input  wire       halfTick,
	input  wire       load,
	input  wire [8:0] loadData,
	input  wire       nineBit,
	input  wire       abort,
	output reg        ckOut,
	output reg        dtOut,
	output reg        busy
);

	// ==========================================
	// Shifter
	reg  [8:0] sr_q;
	reg  [3:0] bitCnt_q;
	reg        nine_q;
	wire [3:0] lastBit;

	assign lastBit = nine_q ? 4'd8 : 4'd7;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sr_q     <= 9'h000;
			bitCnt_q <= 4'h0;
			nine_q   <= 1'b0;
			ckOut    <= 1'b0;
			dtOut    <= 1'b0;
			busy     <= 1'b0;
		end else if (abort) begin
			busy  <= 1'b0;
			ckOut <= 1'b0;
		end else if (load && !busy) begin
			sr_q     <= loadData;
			dtOut    <= loadData[0]; // [RULE20]
			nine_q   <= nineBit; // [RULE14]
			bitCnt_q <= 4'h0;
			ckOut    <= 1'b0;
			busy     <= 1'b1;
		end else if (halfTick && busy) begin
			if (!ckOut) begin
				ckOut <= 1'b1;
			end else begin
				ckOut <= 1'b0;
				if (bitCnt_q == lastBit) begin
					busy <= 1'b0;
				end else begin
					sr_q     <= {1'b0, sr_q[8:1]}; // [RULE20]
					dtOut    <= sr_q[1];
					bitCnt_q <= bitCnt_q + 4'h1;
				end
			end
		end
	end

endmodule // usm_shift

// file: verification/usm_top_sva.sv
// Port checker for the synchronous master transmitter.
// Assumes binding onto usm_top, one clock domain.
`timescale 1ns/1ps

module usm_top_sva (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        ckOut,
	input wire logic        ckOe,
	input wire logic        dtOut,
	input wire logic        baudTick,
	input wire logic        rxInhibit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ====
	// Link sequences
	sequence ckRiseS;
		$rose(ckOut);
	endsequence
	sequence ckHighS;
		ckOut && $past(ckOut);
	endsequence
	// ====
	// Assertions
	bus_okay_a: assert property (hreadyout && !hresp) else $error("Bus not ready or error");
	upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000) else $error("Upper read bits set");
	rise_tick_a: assert property (ckRiseS |-> $past(baudTick)) else $error("Clock rose without tick");
	rise_setup_a: assert property (ckRiseS |-> $stable(dtOut)) else $error("Data moved at rise");
	high_hold_a: assert property (ckHighS |-> $stable(dtOut)) else $error("Data moved while high");
	rise_busy_a: assert property (ckRiseS |-> rxInhibit) else $error("Shift without inhibit");
	tick_pulse_a: assert property (baudTick |=> !baudTick) else $error("Tick wider than one");
	release_low_a: assert property ($fell(ckOe) |=> !ckOut) else $error("Clock high after release");
	idle_low_a: assert property (!rxInhibit && !$past(rxInhibit) |-> !ckOut) else $error("Clock high idle");
endmodule // usm_top_sva

bind usm_top usm_top_sva i_sva (.clk(clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .ckOut(ckOut), .ckOe(ckOe), .dtOut(dtOut), .baudTick(baudTick), .rxInhibit(rxInhibit));

// file: verification/usm_slave.sv
// Receiving slave on the synchronous link.
// Assumes the bench resolves both lines from the enables.
`timescale 1ns/1ps

module usm_slave (
	input  wire logic  ckLine,
	input  wire logic  dtLine,
	output logic [8:0] rxSr,
	output int         rxCount
);
	initial begin
		rxSr = 9'h000;
		rxCount = 0;
	end
	// Sample on rise, first bit lands lowest
	always @(posedge ckLine) begin
		rxSr <= {dtLine, rxSr[8:1]};
		rxCount <= rxCount + 1;
	end
endmodule // usm_slave

// file: verification/usm_top_tb.sv
// Self-checking bench for the synchronous master transmitter.
// Assumes usm_top, its checker and usm_slave are compiled.
`timescale 1ns/1ps
`include "usm_defs.vh"

module usm_top_tb;
	logic        clk;
	logic        nrst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire         hreadyout;
	wire         hresp;
	wire  [31:0] hrdata;
	wire         ckOut;
	wire         ckOe;
	wire         dtOut;
	wire         dtOe;
	wire         baudTick;
	wire         rxInhibit;
	wire         txIrq;
	logic [8:0]  rxSr;
	int          rxCount;
	int          errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          base;
	logic [31:0] rd;

	usm_top i_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ckOut(ckOut), .ckOe(ckOe), .dtOut(dtOut), .dtOe(dtOe), .baudTick(baudTick),
		.rxInhibit(rxInhibit), .txIrq(txIrq));
	usm_slave i_slave (.ckLine(ckOe & ckOut), .dtLine(dtOe ? dtOut : ~dtOut), .rxSr(rxSr), .rxCount(rxCount));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors = errors + 1;
			final_report();
		end
	end
	// ====
	// Shared tasks
	task automatic final_report();
		$display("Compared %0d, mismatched %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h00_0000, e});
	endtask
	task automatic waitTick(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (baudTick !== 1'b1);
	endtask
	task automatic gap(input logic [7:0] ctl, input logic [7:0] x, input int e);
		int n;
		bus(1'b1, `USM_OFS_TXCTL, ctl);
		bus(1'b1, `USM_OFS_DIVISOR, x);
		waitTick(n);
		waitTick(n);
		chk(n, e);
	endtask
	task automatic waitBits(input int n);
		while (rxCount < n) begin
			@(negedge clk);
		end
	endtask
	// ====
	// Scenarios
	task automatic resetCheck();
		rc(`USM_OFS_TXCTL, 8'h02);
		rc(`USM_OFS_DIVISOR, 8'h00);
		rc(`USM_OFS_TXBUF, 8'h00);
		rc(8'h40, 8'h00);
		bus(1'b1, `USM_OFS_TXCTL, 8'h08);
		rc(`USM_OFS_TXCTL, 8'h02);
	endtask
	task automatic rateCheck();
		int n;
		gap(8'h00, 8'h01, 128);
		gap(8'h04, 8'h01, 32);
		gap(8'h10, 8'h01, 4);
		gap(8'h14, 8'hFF, 512);
		gap(8'h00, 8'hFF, 16384);
		bus(1'b1, `USM_OFS_DIVISOR, 8'h00);
		waitTick(n);
		chk({31'h0, n < 70}, 32'h1);
	endtask
	task automatic sendCheck();
		bus(1'b1, `USM_OFS_DIVISOR, 8'h01);
		bus(1'b1, `USM_OFS_RXCTL, 8'h80);
		bus(1'b1, `USM_OFS_TXCTL, 8'h90);
		bus(1'b1, `USM_OFS_IRQCTL, 8'h02);
		bus(1'b1, `USM_OFS_TXCTL, 8'hB0);
		repeat (2) @(negedge clk);
		chk({29'h0, ckOe, dtOe, txIrq}, 32'h7);
		base = rxCount;
		bus(1'b1, `USM_OFS_TXBUF, 8'hA5);
		repeat (12) @(negedge clk);
		bus(1'b1, `USM_OFS_TXBUF, 8'h3C);
		repeat (2) @(negedge clk);
		chk({31'h0, txIrq}, 32'h1);
		repeat (10) @(negedge clk);
		chk({31'h0, txIrq}, 32'h0);
		rc(`USM_OFS_TXCTL, 8'hB0);
		waitBits(base + 8);
		chk({24'h00_0000, rxSr[8:1]}, 32'hA5);
		waitBits(base + 16);
		chk({24'h00_0000, rxSr[8:1]}, 32'h3C);
		bus(1'b1, `USM_OFS_IRQCTL, 8'h00);
		repeat (12) @(negedge clk);
		chk({31'h0, txIrq}, 32'h0);
		rc(`USM_OFS_TXCTL, 8'hB2);
		rc(`USM_OFS_IRQCTL, 8'h01);
	endtask
	task automatic nineCheck();
		base = rxCount;
		bus(1'b1, `USM_OFS_TXCTL, 8'hF1);
		bus(1'b1, `USM_OFS_TXBUF, 8'h5A);
		waitBits(base + 9);
		chk({23'h0, rxSr}, 32'h0000_015A);
	endtask
	task automatic duplexCheck();
		repeat (20) @(negedge clk);
		bus(1'b1, `USM_OFS_RXCTL, 8'hA0);
		@(negedge clk);
		chk({31'h0, dtOe}, 32'h0);
		bus(1'b1, `USM_OFS_RXCTL, 8'h80);
		@(negedge clk);
		chk({31'h0, dtOe}, 32'h1);
		base = rxCount;
		bus(1'b1, `USM_OFS_TXBUF, 8'hFF);
		waitBits(base + 3);
		bus(1'b1, `USM_OFS_TXCTL, 8'h00);
		@(negedge clk);
		chk({30'h0, ckOe, dtOe}, 32'h0);
	endtask

	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		resetCheck();
		rateCheck();
		sendCheck();
		nineCheck();
		duplexCheck();
		final_report();
	end
endmodule // usm_top_tb
